// *** dv/compare_skip_exec_test.sv ***
/*
  Bench for the compare-and-skip block: scenario tasks drive words
  and judge operand address, skip pulse and squashed cycles.
  Assumes csx_pkg, the design and the checker bind are compiled.
*/
`timescale 1ns/1ps
module compare_skip_exec_test;
  import csx_pkg::*;
  logic        clock = 1'h0;
  logic        rst_b = 1'h0;
  logic        ext_set_en = 1'h0;
  logic        instr_valid = 1'h1;
  logic [15:0] instr = 16'h0000;
  logic [7:0]  working_register = 8'h00;
  logic [7:0]  rd_data = 8'h00;
  logic [3:0]  bank_select_register = 4'h0;
  logic [11:0] fsr2_base = 12'h000;
  logic [11:0] rd_addr;
  logic [1:0]  phase;
  logic        rd_en, wr_en, skip_taken, nop_exec, is_compare, cycle_end;
  int          miscompares = 0;
  int          checks_done = 0;

  csx_exec i_dut (.clock, .rst_b, .instr, .instr_valid, .working_register,
    .bank_select_register, .fsr2_base, .ext_set_en, .rd_data, .rd_addr,
    .rd_en, .wr_en, .skip_taken, .nop_exec, .is_compare, .phase,
    .cycle_end);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cmp_addr(input string n, input logic [11:0] e,
                          input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Falling edge before a first-phase sampling edge
  task automatic sync0();
    @(negedge clock);
    while (phase !== 2'h0) @(negedge clock);
  endtask
  // Compare word, its follower, then one more word
  task automatic run_op(input logic [6:0] op, input logic a,
    input logic [7:0] f, input logic [7:0] w, input logic [7:0] d,
    input logic [15:0] nxt);
    logic        sk;
    logic [11:0] ea;
    logic        cp;
    cp = op inside {CSX_OPC_LESS, CSX_OPC_EQUAL, CSX_OPC_GREATER};
    sk = (op == CSX_OPC_GREATER) ? (d > w) : (op == CSX_OPC_LESS) ?
         (d < w) : (op == CSX_OPC_EQUAL) && (d == w);
    ea = a ? {bank_select_register, f} :
         (ext_set_en && f <= CSX_ILO_LIMIT) ? fsr2_base + {4'h0, f} :
         {(f < CSX_ACCESS_SPLIT) ? CSX_ACCESS_LO : CSX_ACCESS_HI, f};
    sync0();
    instr = {op, a, f};
    working_register = w;
    rd_data = d;
    @(negedge clock);
    cmp_bit("rd_en", cp, rd_en);
    @(negedge clock);
    if (op <= CSX_OPC_GREATER) cmp_addr("rd_addr", ea, rd_addr);
    cmp_bit("is_compare", cp, is_compare);
    sync0();
    cmp_bit("skip_taken", sk, skip_taken);
    instr = nxt;
    repeat (2) @(negedge clock);
    cmp_bit("nop_exec", sk, nop_exec);
    cmp_bit("is_compare", !sk && (nxt[15:9] inside {CSX_OPC_LESS,
            CSX_OPC_EQUAL, CSX_OPC_GREATER}), is_compare);
    sync0();
    instr = 16'h0000;
    repeat (2) @(negedge clock);
    cmp_bit("nop_exec", sk && nxt[15:12] == 4'hc, nop_exec);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Each code skips on its own relation; banked operand
  task automatic t_codes();
    bank_select_register = 4'h5;
    run_op(CSX_OPC_GREATER, 1'h1, 8'h10, 8'h20, 8'h21, 16'h0000);
    run_op(CSX_OPC_LESS, 1'h1, 8'hff, 8'h20, 8'h1f, 16'h0000);
    run_op(CSX_OPC_EQUAL, 1'h1, 8'h00, 8'h5a, 8'h5a, 16'h0000);
    run_op(7'h33, 1'h1, 8'h00, 8'h5a, 8'h5b, 16'h0000);
  endtask
  // Unsigned boundaries, a squashed compare, no-skip cases
  task automatic t_unsigned();
    run_op(CSX_OPC_GREATER, 1'h1, 8'h01, 8'h7f, 8'h80, 16'h6400);
    run_op(CSX_OPC_LESS, 1'h1, 8'h02, 8'h80, 8'h7f, 16'h0000);
    run_op(CSX_OPC_GREATER, 1'h1, 8'h03, 8'hc3, 8'hc3, 16'h0000);
    run_op(CSX_OPC_LESS, 1'h1, 8'h04, 8'hc3, 8'hc3, 16'h6000);
    run_op(CSX_OPC_EQUAL, 1'h1, 8'h05, 8'hc3, 8'hc2, 16'h0000);
  endtask
  // Access bank split and indexed window edges
  task automatic t_access();
    fsr2_base = 12'h340;
    run_op(CSX_OPC_EQUAL, 1'h0, 8'h5f, 8'h11, 8'h11, 16'h0000);
    run_op(CSX_OPC_EQUAL, 1'h0, 8'h60, 8'h11, 8'h12, 16'h0000);
    ext_set_en = 1'h1;
    run_op(CSX_OPC_LESS, 1'h0, 8'h5f, 8'h11, 8'h10, 16'h0000);
    run_op(CSX_OPC_LESS, 1'h0, 8'h60, 8'h11, 8'h10, 16'h0000);
    run_op(CSX_OPC_LESS, 1'h1, 8'h20, 8'h11, 8'h10, 16'h0000);
    ext_set_en = 1'h0;
  endtask
  // Two-word follower, with and without a skip
  task automatic t_two_word();
    run_op(CSX_OPC_GREATER, 1'h1, 8'h30, 8'h00, 8'hff, 16'hc012);
    run_op(CSX_OPC_EQUAL, 1'h1, 8'h31, 8'h00, 8'hff, 16'hc012);
  endtask
  // Empty slot after a skip keeps it for the next real word
  task automatic t_bubble();
    sync0();
    instr = {CSX_OPC_EQUAL, 1'h1, 8'h06};
    working_register = 8'h44;
    rd_data = 8'h44;
    sync0();
    cmp_bit("skip_taken", 1'h1, skip_taken);
    instr_valid = 1'h0;
    repeat (2) @(negedge clock);
    cmp_bit("nop_exec", 1'h0, nop_exec);
    sync0();
    instr_valid = 1'h1;
    instr = {CSX_OPC_LESS, 1'h1, 8'h07};
    @(negedge clock);
    cmp_bit("rd_en", 1'h0, rd_en);
    @(negedge clock);
    cmp_bit("nop_exec", 1'h1, nop_exec);
  endtask
  // Reset in mid-run clears outputs, then work resumes
  task automatic t_reset();
    @(negedge clock);
    rst_b = 1'h0;
    @(negedge clock);
    cmp_bit("skip_taken", 1'h0, skip_taken);
    cmp_addr("rd_addr", CSX_ADDR_RST, rd_addr);
    rst_b = 1'h1;
    run_op(CSX_OPC_LESS, 1'h1, 8'h40, 8'h09, 8'h08, 16'hc000);
  endtask

  // Clock, main sequence and watchdog
  always #50 clock = ~clock;
  initial begin
    repeat (10) @(negedge clock);
    rst_b = 1'h1;
    t_codes();
    t_unsigned();
    t_access();
    t_two_word();
    t_bubble();
    t_reset();
    test_done();
  end
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
endmodule

// *** dv/csx_exec_checker.sv ***
/*
  Checker for the compare-and-skip execute block.
  Assumes it is bound to csx_exec and sees only its ports.
*/
`timescale 1ns/1ps
module csx_exec_checker (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [11:0] rd_addr,
  input wire logic        rd_en,
  input wire logic        wr_en,
  input wire logic        skip_taken,
  input wire logic        nop_exec,
  input wire logic [1:0]  phase,
  input wire logic        cycle_end,
  input wire logic        instr_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Output relations
  // ----------------------------------------------------------------
  a_no_write_back: assert property (!wr_en)
    else $error("write strobe raised by a compare");
  a_read_in_q2: assert property (rd_en |-> phase == 2'h1)
    else $error("file read outside the read phase");
  a_end_after_q4: assert property (phase == 2'h3 |=> cycle_end)
    else $error("cycle end missing after last phase");
  a_skip_at_end: assert property (skip_taken |-> cycle_end)
    else $error("skip pulse away from cycle end");
  a_skip_one_pulse: assert property (skip_taken |=> !skip_taken)
    else $error("skip pulse longer than one clock");
  a_skip_from_read: assert property (skip_taken |-> $past(rd_en, 3))
    else $error("skip without an executed compare");
  // No-op flag trails the start of the squashed word by two clocks
  a_squash_four: assert property (skip_taken && instr_valid
    |-> ##2 nop_exec [*4])
    else $error("squashed cycle not four clocks of no-op");
  // Read phase of the squashed word sits one clock before its flag
  a_nop_no_read: assert property (nop_exec && phase == 2'h2
    |-> !$past(rd_en))
    else $error("squashed word read the file");
  a_addr_hold: assert property (phase != 2'h1 |=> $stable(rd_addr))
    else $error("operand address moved outside its phase");
endmodule

bind csx_exec csx_exec_checker i_chk (.clock, .rst_b, .rd_addr, .rd_en,
  .wr_en, .skip_taken, .nop_exec, .phase, .cycle_end, .instr_valid);

// *** logic/csx_addr_gen.sv ***
/*
  Operand address former for the compare-and-skip block.
  Assumes the fsr2 base comes from the core on the same clock.
*/
`timescale 1ns/1ps
module csx_addr_gen (
  input  wire logic        bank_access,
  input  wire logic        ext_set_en,
  input  wire logic [7:0]  file_addr,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] fsr2_base,
  output logic      [11:0] addr
);
  import csx_pkg::*;

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  wire logic        use_ilo;
  wire logic [3:0]  access_bank;
  wire logic [11:0] ilo_addr;

  // Indexed mode only for the common bank, low offsets
  assign use_ilo = !bank_access && ext_set_en &&
                   (file_addr <= CSX_ILO_LIMIT);
  assign access_bank = (file_addr < CSX_ACCESS_SPLIT) ?
                       CSX_ACCESS_LO : CSX_ACCESS_HI;
  assign ilo_addr = fsr2_base + {4'h0, file_addr};
  // Bank select supplies the high bits when the a bit is set
  assign addr = use_ilo     ? ilo_addr :
                bank_access ? {bank_select_register, file_addr}
                            : {access_bank, file_addr};
endmodule

// *** logic/csx_comparator.sv ***
/*
  Unsigned comparator for the compare-and-skip block.
  Assumes both operands are stable through the compare phase.
*/
`timescale 1ns/1ps
module csx_comparator #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] file_byte,
  input  wire logic [WIDTH-1:0] working_register,
  output logic                  is_equal,
  output logic                  is_greater,
  output logic                  is_less
);
  // ----------------------------------------------------------------
  // Subtraction with borrow, result discarded
  // ----------------------------------------------------------------
  wire logic [WIDTH:0] diff;

  // File byte minus working register, unsigned
  assign diff       = {1'b0, file_byte} - {1'b0, working_register};
  assign is_less    = diff[WIDTH];
  assign is_equal   = (diff[WIDTH-1:0] == '0) && !diff[WIDTH];
  assign is_greater = !is_less && !is_equal;
endmodule

// *** logic/csx_exec.sv ***
/*
  Compare-and-skip execute block: decodes the three compare
  instructions, reads the file byte, compares it with the working
  register and squashes the following one or two words on a skip.
  Assumes a core that presents each word in instr at the start of an
  instruction cycle, steps phases with clock and returns read data
  within the third phase. All inputs come from logic on clock.
*/
`timescale 1ns/1ps
module csx_exec (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [15:0] instr,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  working_register,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] fsr2_base,
  input  wire logic        ext_set_en,
  input  wire logic [7:0]  rd_data,
  output logic      [11:0] rd_addr,
  output logic             rd_en,
  output logic             wr_en,
  output logic             skip_taken,
  output logic             nop_exec,
  output logic             is_compare,
  output logic      [1:0]  phase,
  output logic             cycle_end
);
  import csx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csx_phase_t  phase_reg, phase_next;
  logic [15:0] word_reg;
  logic [1:0]  op_reg;        // 0 none, 1 less, 2 equal, 3 greater
  logic        squash_reg;    // Current cycle is a discarded word
  logic        pend_skip_reg; // Skip decided, next word to squash
  logic        second_reg;    // Squashing first word of pair, second follows
  logic [11:0] rd_addr_reg;
  logic        rd_en_reg;
  logic        skip_reg;
  logic        nop_reg;
  logic        cmp_reg;
  logic        end_reg;
  logic [7:0]  file_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [6:0]  opc;
  wire logic        dec_less;
  wire logic        dec_equal;
  wire logic        dec_greater;
  wire logic        dec_any;
  wire logic        two_word;
  wire logic [11:0] op_addr;
  wire logic        c_eq;
  wire logic        c_gt;
  wire logic        c_lt;
  wire logic        hit;
  wire logic        cycle_start;

  // Opcode field compare
  assign opc         = instr[CSX_OPC_MSB:CSX_OPC_LSB];
  assign dec_greater = (opc == CSX_OPC_GREATER);
  assign dec_less    = (opc == CSX_OPC_LESS);
  assign dec_equal   = (opc == CSX_OPC_EQUAL);
  assign dec_any     = dec_less || dec_equal || dec_greater;
  assign cycle_start = (phase_reg == CSX_Q1);
  // Two-word instructions start with a known set of first opcodes
  assign two_word    = (instr[15:12] == 4'hc) ||
                       (instr[15:9] == 7'h76) ||
                       (instr[15:8] == 8'hee) ||
                       (instr[15:8] == 8'hec) ||
                       (instr[15:8] == 8'hed);

  // Operand address from the word held through the cycle
  csx_addr_gen u_addr (
    .bank_access          (word_reg[CSX_ABIT_POS]),
    .ext_set_en           (ext_set_en),
    .file_addr            (word_reg[7:0]),
    .bank_select_register (bank_select_register),
    .fsr2_base            (fsr2_base),
    .addr                 (op_addr)
  );

  // Compare file byte with working register
  csx_comparator #(
    .WIDTH (8)
  ) u_cmp (
    .file_byte        (file_reg),
    .working_register (working_register),
    .is_equal         (c_eq),
    .is_greater       (c_gt),
    .is_less          (c_lt)
  );

  // Outcome per variant
  assign hit = ((op_reg == 2'd1) && c_lt) ||
               ((op_reg == 2'd2) && c_eq) ||
               ((op_reg == 2'd3) && c_gt);

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (phase_reg)
      CSX_Q1:  phase_next = CSX_Q2;
      CSX_Q2:  phase_next = CSX_Q3;
      CSX_Q3:  phase_next = CSX_Q4;
      CSX_Q4:  phase_next = CSX_Q1;
      default: phase_next = CSX_Q1;
    endcase
  end

  // Phase counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= CSX_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Latch word and variant in the decode phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      word_reg   <= 16'h0000;
      op_reg     <= 2'd0;
      squash_reg <= 1'b0;
      second_reg <= 1'b0;
    end else if (cycle_start) begin
      word_reg   <= instr;
      squash_reg <= instr_valid && pend_skip_reg;
      // A two-word target keeps the squash for one more cycle
      second_reg <= instr_valid && pend_skip_reg && !second_reg &&
                    two_word;
      if (!instr_valid || pend_skip_reg) begin
        op_reg <= 2'd0;
      end else if (dec_less) begin
        op_reg <= 2'd1;
      end else if (dec_equal) begin
        op_reg <= 2'd2;
      end else if (dec_greater) begin
        op_reg <= 2'd3;
      end else begin
        op_reg <= 2'd0;
      end
    end
  end

  // File read in the second phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_addr_reg <= CSX_ADDR_RST;
      rd_en_reg   <= 1'b0;
      file_reg    <= CSX_BYTE_RST;
    end else begin
      rd_en_reg <= (phase_reg == CSX_Q1) && (phase_next == CSX_Q2) &&
                   instr_valid && dec_any && !pend_skip_reg;
      if (phase_reg == CSX_Q2) begin
        rd_addr_reg <= op_addr;
      end
      if (phase_reg == CSX_Q3 && op_reg != 2'd0) begin
        file_reg <= rd_data;
      end
    end
  end

  // Skip decision at the end of the compare phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_skip_reg <= 1'b0;
      skip_reg      <= 1'b0;
    end else begin
      skip_reg <= 1'b0;
      if (phase_reg == CSX_Q4 && op_reg != 2'd0 && hit) begin
        pend_skip_reg <= 1'b1;
        skip_reg      <= 1'b1;
      end else if (cycle_start && instr_valid && pend_skip_reg) begin
        // Second word of a pair still has to go
        pend_skip_reg <= !second_reg && two_word;
      end
    end
  end

  // Status outputs, no write-back ever
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nop_reg <= 1'b0;
      cmp_reg <= 1'b0;
      end_reg <= 1'b0;
    end else begin
      nop_reg <= squash_reg;
      cmp_reg <= (op_reg != 2'd0);
      end_reg <= (phase_reg == CSX_Q4);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_addr    = rd_addr_reg;
  assign rd_en      = rd_en_reg;
  assign wr_en      = 1'b0;
  assign skip_taken = skip_reg;
  assign nop_exec   = nop_reg;
  assign is_compare = cmp_reg;
  assign phase      = phase_reg;
  assign cycle_end  = end_reg;
endmodule

// *** logic/csx_pkg.sv ***
/*
  Package for the compare-and-skip execute block: opcode fields,
  phase encoding, address constants and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package csx_pkg;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [6:0] CSX_OPC_LESS    = 7'h30; // 0110 000
  localparam logic [6:0] CSX_OPC_EQUAL   = 7'h31; // 0110 001
  localparam logic [6:0] CSX_OPC_GREATER = 7'h32; // 0110 010
  localparam int         CSX_OPC_MSB     = 15;
  localparam int         CSX_OPC_LSB     = 9;
  localparam int         CSX_ABIT_POS    = 8;

  // ----------------------------------------------------------------
  // Second word prefix of two-word instructions (upper nibble 1111)
  // ----------------------------------------------------------------
  localparam logic [3:0] CSX_SECOND_WORD_NIB = 4'hf;

  // ----------------------------------------------------------------
  // Addressing constants
  // ----------------------------------------------------------------
  localparam logic [7:0] CSX_ILO_LIMIT    = 8'h5f; // 95
  localparam logic [7:0] CSX_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] CSX_ACCESS_HI    = 4'hf;
  localparam logic [3:0] CSX_ACCESS_LO    = 4'h0;

  // ----------------------------------------------------------------
  // Phases and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CSX_Q1, CSX_Q2, CSX_Q3, CSX_Q4} csx_phase_t;
  localparam logic [7:0]  CSX_BYTE_RST = 8'h00;
  localparam logic [11:0] CSX_ADDR_RST = 12'h000;

endpackage
